// file: hdl/ccg_top.sv
// output gating, stop and power-down sequencing with its control byte port
//
// How it works
// - soft halt bit low stops stoppable bus, free and serial clocks cleanly, except the serial comp, whose pulse can be cut short
// - pci enable byte bits 6..0 enable bus clocks 6..0, reset ones
// - usb byte bit 7 selects usb drive, 0 high, 1 low, reset zero
// - usb byte bit 6 enables the usb 48 MHz clock, reset enabled
// - usb byte bits 5..3 make free bus clocks 2..0 stoppable
// - usb byte bits 2..0 enable free bus clocks 2..0, reset ones
// - mid byte bit 7 enables dot clock, bits 4..0 mid clocks
// - mid byte bit 5 switches mid clock 4 to video hub mode
// - misc byte bit 5 puts frequency selects into test mode
// - misc byte bit 4 selects serial clock 100 or 200 MHz
// - misc byte bit 2 turns spread spectrum on
// - misc byte bits 1..0 enable reference clocks 1..0
// - identification byte returns fixed revision and maker codes
// - power-down input synchronised, then clocks held low except host true, pll off
// - after two low samples on comp rises, outputs held low, true high
// - reference clocks may take more than one cycle to stop
// - after power-down release clocks restart once a 1.8 ms relock count from the synchronised release ends
// - host stop taken on two true rises, true held high, comp undriven
// - host stop release resumes within two host cycles, no odd pulses
// - bus halt is pin OR soft bit, status bit 3 reads zero when halted
// - bus halt release restarts stoppable clocks within two periods
`default_nettype none
`include "ccg_map.svh"

module ccg_top #(
    parameter int RELOCK_CYCLES = `CCG_RELOCK_NS / `CCG_CLK_PERIOD_NS,
    parameter logic [3:0] REV_CODE   = 4'h3, // arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'h5  // arbitrary value
) (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    // byte command port
    input  wire logic [7:0] reg_cmd,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata_q,
    output logic            reg_ack_q,
    // system stop and power-down pins
    input  wire logic       bus_clock_halt_n,
    input  wire logic       host_clock_halt_n,
    input  wire logic       power_down_n,
    input  wire logic [2:0] host_stoppable,
    input  wire logic       src_stoppable,
    // ungated clock phases from the synthesizer
    input  wire logic       pci_phase,
    input  wire logic       mid_phase,
    input  wire logic       vch_phase,
    input  wire logic       usb_phase,
    input  wire logic       ref_phase,
    input  wire logic       src_phase,
    input  wire logic       host_phase,
    // gated clock outputs
    output logic      [6:0] bus_clock_q,
    output logic      [2:0] free_bus_clock_q,
    output logic      [4:0] mid_freq_clock_q,
    output logic            dot_pixel_48m_clock_q,
    output logic            usb_48m_clock_q,
    output logic      [1:0] ref_clock_q,
    output logic            serial_ref_true_q,
    output logic            serial_ref_comp_q,
    output logic      [2:0] host_clock_true_q,
    output logic      [2:0] host_clock_comp_q,
    output logic      [2:0] host_clock_comp_oe_q,
    // analog and mode controls
    output logic            pll_on_q,
    output logic            usb_low_drive_q,
    output logic            video_hub_mode_q,
    output logic            freq_select_test_q,
    output logic            src_200m_q,
    output logic            spread_on_q,
    output logic            bus_running_q
);

    localparam int NOUT = 20;

    // control bytes
    logic [7:0] pci_en_q, pci_en_d;
    logic [7:0] usb_free_q, usb_free_d;
    logic [7:0] mid_en_q, mid_en_d;
    logic [7:0] misc_q, misc_d;
    logic       pci_go;
    logic [7:0] rdata_d;
    logic       ack_d;
    logic       cmd_ok;
    logic [4:0] ofs;

    // byte commands outside the 100 pattern get no acknowledge
    always_comb begin
        ofs        = reg_cmd[4:0];
        cmd_ok     = (reg_cmd[7:5] == `CCG_CMD_BYTE_OP);
        pci_en_d   = pci_en_q;
        usb_free_d = usb_free_q;
        mid_en_d   = mid_en_q;
        misc_d     = misc_q;
        rdata_d    = reg_rdata_q;
        ack_d      = 1'b0;
        if (cmd_ok && reg_wr) begin
            ack_d = 1'b1;
            case (ofs)
                `CCG_OFS_PCI_EN:   pci_en_d   = reg_wdata;
                `CCG_OFS_USB_FREE: usb_free_d = reg_wdata;
                `CCG_OFS_MID_EN:   mid_en_d   = reg_wdata;
                `CCG_OFS_MISC:     misc_d     = reg_wdata;
                default:           ack_d      = 1'b1; // read-only or unmapped
            endcase
        end else if (cmd_ok && reg_rd) begin
            ack_d = 1'b1;
            case (ofs)
                `CCG_OFS_STATUS: begin
                    rdata_d = 8'h00;
                    rdata_d[`CCG_BIT_STAT_PCI]  = pci_go;
                    rdata_d[`CCG_BIT_STAT_HOST] = host_clock_halt_n;
                end
                `CCG_OFS_PCI_EN:   rdata_d = pci_en_q;
                `CCG_OFS_USB_FREE: rdata_d = usb_free_q;
                `CCG_OFS_MID_EN:   rdata_d = mid_en_q;
                `CCG_OFS_MISC:     rdata_d = misc_q;
                `CCG_OFS_IDENT:    rdata_d = {REV_CODE, MAKER_CODE};
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pci_en_q    <= `CCG_RST_PCI_EN;
            usb_free_q  <= `CCG_RST_USB_FREE;
            mid_en_q    <= `CCG_RST_MID_EN;
            misc_q      <= `CCG_RST_MISC;
            reg_rdata_q <= 8'h00;
            reg_ack_q   <= 1'b0;
        end else if (clk_en) begin
            pci_en_q    <= pci_en_d;
            usb_free_q  <= usb_free_d;
            mid_en_q    <= mid_en_d;
            misc_q      <= misc_d;
            reg_rdata_q <= rdata_d;
            reg_ack_q   <= ack_d;
        end
    end

    // power-down: two-flop synchroniser, then sampling on comp rising edges
    ccg_pkg::ccg_pd_state_t pd_state_q, pd_state_d;
    logic        pd_s1_q, pd_s2_q;
    logic        host_ph_q;
    logic [16:0] relock_q, relock_d;
    logic        comp_rise, true_rise, pd_hold;

    assign comp_rise = host_ph_q && !host_phase;
    assign true_rise = !host_ph_q && host_phase;
    assign pd_hold   = (pd_state_q == ccg_pkg::CCG_DOWN) ||
                       (pd_state_q == ccg_pkg::CCG_RELOCK);

    always_comb begin
        pd_state_d = pd_state_q;
        relock_d   = relock_q;
        case (pd_state_q)
            ccg_pkg::CCG_RUN:
                if (comp_rise && !pd_s2_q) pd_state_d = ccg_pkg::CCG_PD_ARM;
            ccg_pkg::CCG_PD_ARM:
                if (comp_rise) begin
                    pd_state_d = pd_s2_q ? ccg_pkg::CCG_RUN : ccg_pkg::CCG_DOWN;
                end
            ccg_pkg::CCG_DOWN:
                if (pd_s2_q) begin
                    pd_state_d = ccg_pkg::CCG_RELOCK;
                    relock_d   = 17'(RELOCK_CYCLES - 1);
                end
            ccg_pkg::CCG_RELOCK: begin
                // relock time counts from the synchronised release
                if (relock_q == 17'h0_0000) pd_state_d = ccg_pkg::CCG_RUN;
                else relock_d = relock_q - 17'h0_0001;
            end
            default: pd_state_d = ccg_pkg::CCG_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pd_s1_q    <= 1'b1;
            pd_s2_q    <= 1'b1;
            host_ph_q  <= 1'b0;
            pd_state_q <= ccg_pkg::CCG_RUN;
            relock_q   <= 17'h0_0000;
        end else if (clk_en) begin
            pd_s1_q    <= power_down_n;
            pd_s2_q    <= pd_s1_q;
            host_ph_q  <= host_phase;
            pd_state_q <= pd_state_d;
            relock_q   <= relock_d;
        end
    end

    // host stop: taken after two true rising edges, released in the next high phase
    logic [1:0] hcnt_q, hcnt_d;
    logic [2:0] hstop_q, hstop_d;
    logic       hreq;
    logic [2:0] htrue_d, hcomp_d, hoe_d;

    always_comb begin
        hcnt_d = hcnt_q;
        if (host_clock_halt_n) hcnt_d = 2'd0;
        else if (true_rise && hcnt_q != `CCG_HALT_EDGES) hcnt_d = hcnt_q + 2'd1;
        hreq = (hcnt_q == `CCG_HALT_EDGES);
        for (int i = 0; i < 3; i++) begin
            hstop_d[i] = hstop_q[i];
            // change only in the high phase: stop holds high, restart keeps full pulse
            if (host_phase) hstop_d[i] = hreq && host_stoppable[i];
            htrue_d[i] = pd_hold || hstop_d[i] || host_phase;
            hcomp_d[i] = !htrue_d[i];
            hoe_d[i]   = !(pd_hold || hstop_d[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hcnt_q               <= 2'd0;
            hstop_q              <= 3'b000;
            host_clock_true_q    <= 3'b000;
            host_clock_comp_q    <= 3'b000;
            host_clock_comp_oe_q <= 3'b000;
        end else if (clk_en) begin
            hcnt_q               <= hcnt_d;
            hstop_q              <= hstop_d;
            host_clock_true_q    <= htrue_d;
            host_clock_comp_q    <= hcomp_d & hoe_d;
            host_clock_comp_oe_q <= hoe_d;
        end
    end

    // single-ended and serial outputs: run conditions per output
    logic [NOUT-1:0] ph, en, stoppable, run;
    logic [NOUT-1:0] gate_q, gate_d, out_q, out_d;
    logic            src_comp_d, src_comp_q;

    assign pci_go    = bus_clock_halt_n && pci_en_q[`CCG_BIT_SOFT_HALT];
    assign ph        = {src_phase, {2{ref_phase}}, usb_phase, usb_phase,
                        (mid_en_q[`CCG_BIT_VCH_MODE] ? vch_phase : mid_phase),
                        {4{mid_phase}}, {3{pci_phase}}, {7{pci_phase}}};
    assign en        = {1'b1, misc_q[1:0], usb_free_q[`CCG_BIT_USB_EN],
                        mid_en_q[`CCG_BIT_DOT_EN], mid_en_q[4:0],
                        usb_free_q[2:0], pci_en_q[6:0]};
    assign stoppable = {src_stoppable, 9'h000,
                        usb_free_q[`CCG_POS_FREE_STOP +: 3], 7'h7f};

    // gates move only while the phase is low, so no runt or stretched pulse
    genvar g;
    generate
        for (g = 0; g < NOUT; g++) begin : g_out
            assign run[g]    = en[g] && !pd_hold && !(stoppable[g] && !pci_go);
            assign gate_d[g] = ph[g] ? gate_q[g] : run[g];
            assign out_d[g]  = ph[g] && gate_d[g];
        end
    endgenerate

    assign src_comp_d = !src_phase && gate_d[NOUT-1];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            gate_q     <= '0;
            out_q      <= '0;
            src_comp_q <= 1'b0;
        end else if (clk_en) begin
            gate_q     <= gate_d;
            out_q      <= out_d;
            src_comp_q <= src_comp_d;
        end
    end

    assign bus_clock_q           = out_q[6:0];
    assign free_bus_clock_q      = out_q[9:7];
    assign mid_freq_clock_q      = out_q[14:10];
    assign dot_pixel_48m_clock_q = out_q[15];
    assign usb_48m_clock_q       = out_q[16];
    assign ref_clock_q           = out_q[18:17];
    assign serial_ref_true_q     = out_q[19];
    assign serial_ref_comp_q     = src_comp_q;

    // mode controls registered toward the analog side
    logic [6:0] mode_d;

    always_comb begin
        mode_d = {!pd_hold || pd_s2_q,                      // pll back on at release
                  usb_free_q[`CCG_BIT_USB_DRIVE],
                  mid_en_q[`CCG_BIT_VCH_MODE],
                  misc_q[`CCG_BIT_TEST_MODE],
                  misc_q[`CCG_BIT_SRC_200M],
                  misc_q[`CCG_BIT_SPREAD],
                  pci_go};
        if (pd_state_q == ccg_pkg::CCG_DOWN) mode_d[6] = pd_s2_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            {pll_on_q, usb_low_drive_q, video_hub_mode_q, freq_select_test_q,
             src_200m_q, spread_on_q, bus_running_q} <= 7'h41;
        end else if (clk_en) begin
            {pll_on_q, usb_low_drive_q, video_hub_mode_q, freq_select_test_q,
             src_200m_q, spread_on_q, bus_running_q} <= mode_d;
        end
    end

endmodule
`default_nettype wire

// file: hdl/ccg_map.svh
// register offsets, field positions, reset values and timing counts of the clock gating block
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

`define CCG_CMD_BYTE_OP     3'b100
`define CCG_OFS_STATUS      5'h00
`define CCG_OFS_PCI_EN      5'h03
`define CCG_OFS_USB_FREE    5'h04
`define CCG_OFS_MID_EN      5'h05
`define CCG_OFS_MISC        5'h06
`define CCG_OFS_IDENT       5'h07

`define CCG_RST_PCI_EN      8'hff
`define CCG_RST_USB_FREE    8'h47
`define CCG_RST_MID_EN      8'hdf
`define CCG_RST_MISC        8'h03

`define CCG_BIT_SOFT_HALT   7
`define CCG_BIT_USB_DRIVE   7
`define CCG_BIT_USB_EN      6
`define CCG_POS_FREE_STOP   3
`define CCG_BIT_DOT_EN      7
`define CCG_BIT_VCH_MODE    5
`define CCG_BIT_TEST_MODE   5
`define CCG_BIT_SRC_200M    4
`define CCG_BIT_SPREAD      2
`define CCG_BIT_STAT_PCI    3
`define CCG_BIT_STAT_HOST   2

`define CCG_HALT_EDGES      2'd2
`define CCG_CLK_PERIOD_NS   25
`define CCG_RELOCK_NS       1800000

`endif

// file: hdl/ccg_pkg.sv
// shared types of the clock gating block
`default_nettype none
package ccg_pkg;
    typedef enum logic [1:0] {
        CCG_RUN,
        CCG_PD_ARM,
        CCG_DOWN,
        CCG_RELOCK
    } ccg_pd_state_t;
endpackage
`default_nettype wire

// file: test/ccg_sva.sv
// assertion checker for the clock gating block, bound to its top
`default_nettype none
module ccg_sva (
    // clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    // byte command port
    input wire logic [7:0] reg_cmd,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       reg_ack_q,
    // stop pins and phases
    input wire logic       bus_clock_halt_n,
    input wire logic       host_clock_halt_n,
    input wire logic [2:0] host_stoppable,
    input wire logic       pci_phase,
    input wire logic       ref_phase,
    // gated outputs
    input wire logic [6:0] bus_clock_q,
    input wire logic [2:0] free_bus_clock_q,
    input wire logic [1:0] ref_clock_q,
    input wire logic [2:0] host_clock_true_q,
    input wire logic [2:0] host_clock_comp_q,
    input wire logic [2:0] host_clock_comp_oe_q,
    input wire logic       pll_on_q,
    input wire logic       bus_running_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] pd_q;
    logic [3:0] hs_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // saturating run lengths; fixed windows would miss slow phases
    always_ff @(posedge clk) begin
        pd_q <= (!resetn || pll_on_q) ? 4'h0 : pd_q + {3'h0, pd_q != 4'hf};
        hs_q <= (!resetn || host_clock_halt_n) ? 4'h0 : hs_q + {3'h0, hs_q != 4'hf};
    end
    property p_ack;
        (reg_wr || reg_rd) && clk_en && reg_cmd[7:5] == 3'b100 |=> reg_ack_q;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_nack;
        clk_en && !((reg_wr || reg_rd) && reg_cmd[7:5] == 3'b100) |=> !reg_ack_q;
    endproperty
    a_nack: assert property (p_nack) else $error("stray ack");
    property p_rdata;
        !reg_rd |=> $stable(reg_rdata_q);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    property p_run;
        !bus_clock_halt_n && clk_en |=> !bus_running_q;
    endproperty
    a_run: assert property (p_run) else $error("bus halt not seen");
    property p_bus_low;
        |{bus_clock_q, free_bus_clock_q} |-> $past(pci_phase);
    endproperty
    a_bus_low: assert property (p_bus_low) else $error("bus clock runt");
    property p_ref;
        |ref_clock_q |-> $past(ref_phase);
    endproperty
    a_ref: assert property (p_ref) else $error("ref clock runt");
    property p_comp;
        (host_clock_comp_q & ~host_clock_comp_oe_q) == 3'b000;
    endproperty
    a_comp: assert property (p_comp) else $error("comp high undriven");
    property p_pd;
        pd_q > 4'ha |-> {bus_clock_q, free_bus_clock_q, ref_clock_q} == 12'h000
            && host_clock_true_q == 3'b111 && host_clock_comp_oe_q == 3'b000;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down outputs");
    property p_hs;
        hs_q == 4'hf |-> (host_clock_true_q & host_stoppable) == host_stoppable;
    endproperty
    a_hs: assert property (p_hs) else $error("host halt late");
    property p_resume;
        $rose(host_clock_halt_n) && pll_on_q |-> ##[1:10] host_clock_comp_oe_q == 3'b111;
    endproperty
    a_resume: assert property (p_resume) else $error("host resume late");
    c_rd: cover property (reg_rd ##1 reg_ack_q);
    c_pd: cover property ($fell(pll_on_q));
    c_halt: cover property ($fell(bus_running_q));
endmodule
bind ccg_top ccg_sva ccg_sva_inst (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .bus_clock_halt_n(bus_clock_halt_n), .host_clock_halt_n(host_clock_halt_n),
    .host_stoppable(host_stoppable), .pci_phase(pci_phase), .ref_phase(ref_phase),
    .bus_clock_q(bus_clock_q), .free_bus_clock_q(free_bus_clock_q),
    .ref_clock_q(ref_clock_q), .host_clock_true_q(host_clock_true_q),
    .host_clock_comp_q(host_clock_comp_q), .host_clock_comp_oe_q(host_clock_comp_oe_q),
    .pll_on_q(pll_on_q), .bus_running_q(bus_running_q));
`default_nettype wire

// file: test/ccg_phase_src.sv
// synthesizer phase source standing in for the pll dividers
`default_nettype none
module ccg_phase_src (
    // clock
    input  wire logic clk,
    // ungated phases, period 4 and 8 cycles
    output logic      fast_phase,
    output logic      slow_phase
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_q = 3'h0;
    // free running: the real dividers ignore the block's reset
    always_ff @(posedge clk) begin
        div_q <= div_q + 3'h1;
    end
    assign fast_phase = div_q[1];
    assign slow_phase = div_q[2];
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the clock gating block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] REV = 4'h6; // arbitrary value
    localparam logic [3:0] MKR = 4'h9; // arbitrary value
    typedef struct packed {logic [7:0] e; logic [7:0] m;} ccg_note_t;
    typedef struct packed {
        logic [6:0] bus; logic [2:0] fre; logic [4:0] mid; logic dot; logic usb;
        logic [1:0] rf; logic sr; logic [2:0] oe;
    } ccg_seen_t;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic bus_n = 1'b1, host_n = 1'b1, pd_n = 1'b1, src_stp = 1'b0, clk_en = 1'b1;
    logic [7:0] reg_cmd = 8'h00, reg_wdata = 8'h00, rdata, d3, d4, d5, d6;
    logic [2:0] host_stp = 3'b000, free, ht, hc, hoe;
    logic [6:0] bus;
    logic [4:0] mid;
    logic [1:0] refc;
    logic fast, slow, ack, dot, usb, srt, src, pll, usb_lo, vhm, fst, s200, spr, run;
    logic [31:0] r = 32'h776b_2c3f;
    int errors = 0, tests_run = 0;
    ccg_note_t notes[$];
    ccg_note_t n;
    ccg_seen_t seen;
    ccg_phase_src ccg_phase_src_inst (.clk(clk), .fast_phase(fast), .slow_phase(slow));
    ccg_top #(.RELOCK_CYCLES(20), .REV_CODE(REV), .MAKER_CODE(MKR)) ccg_top_inst (
        .clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .reg_ack_q(ack),
        .bus_clock_halt_n(bus_n), .host_clock_halt_n(host_n), .power_down_n(pd_n),
        .host_stoppable(host_stp), .src_stoppable(src_stp), .pci_phase(fast),
        .mid_phase(fast), .vch_phase(slow), .usb_phase(slow), .ref_phase(slow),
        .src_phase(fast), .host_phase(fast), .bus_clock_q(bus), .free_bus_clock_q(free),
        .mid_freq_clock_q(mid), .dot_pixel_48m_clock_q(dot), .usb_48m_clock_q(usb),
        .ref_clock_q(refc), .serial_ref_true_q(srt), .serial_ref_comp_q(src),
        .host_clock_true_q(ht), .host_clock_comp_q(hc), .host_clock_comp_oe_q(hoe),
        .pll_on_q(pll), .usb_low_drive_q(usb_lo), .video_hub_mode_q(vhm),
        .freq_select_test_q(fst), .src_200m_q(s200), .spread_on_q(spr), .bus_running_q(run));
    // 25 ns clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic stop_test;
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one byte transfer; refused commands leave no note
    task automatic xfer(input bit wr, input logic [7:0] c, input logic [7:0] d,
                        input logic [7:0] m);
        @(posedge clk);
        if (c[7:5] == 3'b100) notes.push_back({d, m});
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_cmd <= c;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
    endtask
    // which outputs went high within k cycles
    task automatic watch(input int k);
        seen = '0;
        repeat (k) begin
            @(negedge clk);
            seen |= {bus, free, mid, dot, usb, refc, srt, hoe};
        end
    endtask
    // halt by pin or soft bit, then release
    task automatic halt(input bit pin);
        @(posedge clk);
        bus_n <= !pin;
        if (!pin) xfer(1, 8'h83, 8'h7f, 8'h00);
        watch(8);
        watch(16);
        chk("bus", 0, seen.bus);
        chk("free", 3'b010, seen.fre);
        chk("serial", 0, seen.sr);
        chk("serial_c", 0, src);
        chk("run", 0, run);
        xfer(0, 8'h80, 8'h00, 8'h08);
        @(posedge clk);
        bus_n <= 1'b1;
        xfer(1, 8'h83, 8'hff, 8'h00);
        watch(10);
        chk("restart", 10'h3ff, {seen.fre, seen.bus});
    endtask
    // oldest note against every acknowledged transfer
    always @(negedge clk) begin
        if (ack === 1'b1) begin
            if (notes.size() == 0) chk("ack", 0, 1);
            else begin
                n = notes.pop_front();
                chk("rdata", n.e & n.m, rdata & n.m);
            end
        end
    end
    initial begin
        #(25 * 5000);
        errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        xfer(0, 8'h83, 8'hff, 8'hff);
        xfer(0, 8'h84, 8'h47, 8'hff);
        xfer(0, 8'h85, 8'hdf, 8'hff);
        xfer(0, 8'h86, 8'h03, 8'hff);
        chk("modes", 0, {usb_lo, vhm, fst, s200, spr});
        xfer(1, 8'h87, 8'h00, 8'h00);
        xfer(0, 8'h87, {REV, MKR}, 8'hff);
        xfer(0, 8'h9f, 8'h00, 8'hff);
        xfer(1, 8'h03, 8'h00, 8'h00);
        xfer(0, 8'h83, 8'hff, 8'hff);
        // random enables and modes, reserved bits at their fixed values
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            d3 = {1'b1, r[6:0]};
            d4 = r[15:8];
            d5 = r[23:16] | 8'h40;
            d6 = r[31:24] & 8'h37;
            xfer(1, 8'h83, d3, 8'h00);
            xfer(1, 8'h84, d4, 8'h00);
            xfer(1, 8'h85, d5, 8'h00);
            xfer(1, 8'h86, d6, 8'h00);
            xfer(0, 8'h84, d4, 8'hff);
            xfer(0, 8'h86, d6, 8'hff);
            chk("modes", {d4[7], d5[5]}, {usb_lo, vhm});
            chk("modes", {d6[5], d6[4], d6[2]}, {fst, s200, spr});
            watch(16);
            chk("bus", d3[6:0], seen.bus);
            chk("free", d4[2:0], seen.fre);
            chk("mid", d5[4:0], seen.mid);
            chk("misc", {d5[7], d4[6], d6[1:0]}, {seen.dot, seen.usb, seen.rf});
        end
        @(posedge clk);
        src_stp <= 1'b1;
        xfer(1, 8'h84, 8'h2f, 8'h00);
        halt(0);
        halt(1);
        // host pairs 2 and 0 obey the halt, pair 1 keeps running
        @(posedge clk);
        host_stp <= 3'b101;
        host_n <= 1'b0;
        watch(16);
        watch(8);
        chk("host_oe", 3'b010, seen.oe);
        chk("host_true", 3'b101, ht & 3'b101);
        chk("host_comp", 3'b000, hc & 3'b101);
        @(posedge clk);
        host_n <= 1'b1;
        watch(10);
        chk("host_oe", 3'b111, seen.oe);
        // power-down entry, relock hold and restart
        @(posedge clk);
        pd_n <= 1'b0;
        watch(20);
        watch(8);
        chk("pll", 0, pll);
        chk("pd_out", 0, seen);
        chk("pd_true", 3'b111, ht);
        // frozen block must not see the release until enabled again
        @(posedge clk);
        clk_en <= 1'b0;
        pd_n <= 1'b1;
        watch(8);
        chk("freeze", 0, pll);
        @(posedge clk);
        clk_en <= 1'b1;
        watch(6);
        watch(12);
        chk("relock", 0, seen.bus);
        chk("pll", 1, pll);
        watch(20);
        watch(10);
        chk("pd_exit", 7'h7f, seen.bus);
        stop_test();
    end
endmodule
`default_nettype wire
